/* File: core/e1rx_ctl.sv */
// E1 receive payload control and signaling extractor with register port
`timescale 1ns/100ps
`default_nettype none
`include "e1rx_regs.svh"
module e1rx_ctl (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic rx_valid_i,
  input wire logic [4:0] rx_ts_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic first_frame_i,
  input wire logic mf_sync_i,
  input wire logic rx_sig_valid_i,
  input wire logic [4:0] rx_sig_ts_i,
  input wire logic [3:0] rx_sig_i,
  output logic [7:0] rx_data_o,
  output logic rx_data_valid_o,
  output logic [4:0] rx_ts_o,
  output logic [3:0] rx_signaling_output_o,
  output logic int_n_o
);
  import e1rx_pkg::*;

  e1rx_state_t q;
  e1rx_state_t d;

  function automatic logic pay_addr_ok(input logic [6:0] a);
    pay_addr_ok = (a <= 7'h3f) || (a >= 7'h41 && a <= 7'h4f) || (a >= 7'h51 && a <= 7'h5f);
  endfunction

  function automatic logic sig_slot_ok(input logic [6:0] a);
    sig_slot_ok = (a != 7'h00) && (a != 7'h10) && (a <= 7'h1f);
  endfunction

  // Timeslot 16 carries the signaling itself and owns no flag
  function automatic logic [4:0] flag_idx(input logic [4:0] t);
    flag_idx = (t < `E1RX_TS_SIGNALING) ? t - 5'h01 : t - 5'h02;
  endfunction

  function automatic logic [7:0] milliwatt(input logic mu, input logic [2:0] ph);
    logic [7:0] v;
    v = 8'h00;
    case (ph)
      3'h0, 3'h3: v = mu ? 8'h1e : 8'h34;
      3'h1, 3'h2: v = mu ? 8'h0b : 8'h21;
      3'h4, 3'h7: v = mu ? 8'h9e : 8'hb4;
      default: v = mu ? 8'h8b : 8'ha1;
    endcase
    milliwatt = v;
  endfunction

  logic [7:0] slot_ent;
  logic [7:0] slot_trunk;
  logic [7:0] slot_cond;
  logic [3:0] sig_base;
  logic [6:0] pay_a;
  logic [6:0] sig_a;
  logic [4:0] sig_t;

  always_comb
  begin
    d = q;
    d.rdata = 8'h00;
    pay_a = q.pay_ctl[6:0];
    sig_a = q.sig_ctl[6:0];
    sig_t = rx_sig_ts_i;
    slot_ent = q.pay_mem[{2'b00, rx_ts_i}];
    slot_trunk = q.pay_mem[{2'b01, rx_ts_i}];
    slot_cond = q.pay_mem[{2'b10, rx_ts_i}];
    sig_base = 4'h0;

    // Register writes; control and data writes to a busy unit are ignored
    if (wr_i)
    begin
      case (addr_i)
        `E1RX_PAY_CONTROL:
          if (q.pay_st == E1RX_IDLE)
          begin
            d.pay_ctl = wdata_i;
            d.pay_st = E1RX_XFER;
          end
        `E1RX_PAY_DATA:
          if (q.pay_st == E1RX_IDLE)
          begin
            d.pay_dat = wdata_i;
          end
        `E1RX_PAY_CONFIG: d.pay_cfg = wdata_i & `E1RX_CFG_MASK;
        `E1RX_PAY_ENABLE: d.pay_en = wdata_i[0];
        `E1RX_SIG_CONFIG: d.sig_cfg = wdata_i & `E1RX_SIGCFG_MASK;
        `E1RX_SIG_CONTROL:
          if (q.sig_st == E1RX_IDLE)
          begin
            d.sig_ctl = wdata_i;
            d.sig_st = E1RX_XFER;
          end
        `E1RX_SIG_DATA:
          if (q.sig_st == E1RX_IDLE)
          begin
            d.sig_dat = wdata_i;
          end
        `E1RX_SIG_FLAGS0: d.flags[7:0] = q.flags[7:0] & ~wdata_i;
        `E1RX_SIG_FLAGS1: d.flags[15:8] = q.flags[15:8] & ~wdata_i;
        `E1RX_SIG_FLAGS2: d.flags[23:16] = q.flags[23:16] & ~wdata_i;
        `E1RX_SIG_FLAGS3: d.flags[29:24] = q.flags[29:24] & ~wdata_i[5:0];
        default: d.rdata = 8'h00;
      endcase
    end

    // Register reads, answered in the next cycle
    if (rd_i)
    begin
      case (addr_i)
        `E1RX_PAY_STATUS: d.rdata = {7'h00, q.pay_st == E1RX_XFER};
        `E1RX_PAY_CONTROL: d.rdata = q.pay_ctl;
        `E1RX_PAY_DATA: d.rdata = q.pay_dat;
        `E1RX_PAY_CONFIG: d.rdata = q.pay_cfg;
        `E1RX_PAY_ENABLE: d.rdata = {7'h00, q.pay_en};
        `E1RX_SIG_CONFIG: d.rdata = q.sig_cfg;
        `E1RX_SIG_STATUS: d.rdata = {7'h00, q.sig_st == E1RX_XFER};
        `E1RX_SIG_CONTROL: d.rdata = q.sig_ctl;
        `E1RX_SIG_DATA: d.rdata = q.sig_dat;
        `E1RX_SIG_FLAGS0: d.rdata = q.flags[7:0];
        `E1RX_SIG_FLAGS1: d.rdata = q.flags[15:8];
        `E1RX_SIG_FLAGS2: d.rdata = q.flags[23:16];
        `E1RX_SIG_FLAGS3: d.rdata = {2'b00, q.flags[29:24]};
        default: d.rdata = 8'h00;
      endcase
    end

    // Payload indirect transfer; an invalid address only pulses busy
    case (q.pay_st)
      E1RX_XFER:
      begin
        if (pay_addr_ok(pay_a))
        begin
          if (q.pay_ctl[`E1RX_BIT_RWN])
            d.pay_dat = q.pay_mem[pay_a];
          else
            d.pay_mem[pay_a] = q.pay_dat;
        end
        d.pay_st = E1RX_IDLE;
      end
      E1RX_IDLE: d.pay_st = d.pay_st;
      default: d.pay_st = E1RX_IDLE;
    endcase

    // Signaling indirect transfer
    case (q.sig_st)
      E1RX_XFER:
      begin
        if (sig_slot_ok(sig_a))
        begin
          if (q.sig_ctl[`E1RX_BIT_RWN])
            d.sig_dat = {4'h0, q.sig_mem[sig_a[4:0]]};
          else
            d.sig_mem[sig_a[4:0]] = q.sig_dat[3:0];
        end
        d.sig_st = E1RX_IDLE;
      end
      E1RX_IDLE: d.sig_st = d.sig_st;
      default: d.sig_st = E1RX_IDLE;
    endcase

    // Received signaling: debounce, freeze, change detection; set wins over clear
    if (rx_sig_valid_i && sig_slot_ok({2'b00, sig_t}))
    begin
      d.sig_prev[sig_t] = rx_sig_i;
      if (!q.sig_cfg[`E1RX_BIT_FREEZE])
      begin
        if (!q.sig_cfg[`E1RX_BIT_DEB] || rx_sig_i == q.sig_prev[sig_t])
        begin
          d.sig_mem[sig_t] = rx_sig_i;
          if (rx_sig_i != q.sig_mem[sig_t])
            d.flags[flag_idx(sig_t)] = 1'b1;
        end
      end
    end

    // Receive payload path
    d.dvalid = rx_valid_i;
    if (rx_valid_i)
    begin
      d.ts = rx_ts_i;
      if (rx_ts_i == 5'h1f)
        d.mw_phase = q.mw_phase + 3'h1;
      if (first_frame_i)
        d.snap[rx_ts_i] = q.sig_mem[rx_ts_i];
      d.data = rx_byte_i;
      if (q.pay_en)
      begin
        case (q.pay_cfg[2:0])
          `E1RX_SUB_SLOT:
            case (slot_ent[7:5])
              `E1RX_SUB_TRUNK: d.data = slot_trunk;
              `E1RX_SUB_ALAW: d.data = milliwatt(1'b0, q.mw_phase);
              `E1RX_SUB_MULAW: d.data = milliwatt(1'b1, q.mw_phase);
              default: d.data = rx_byte_i;
            endcase
          `E1RX_SUB_TRUNK: d.data = slot_trunk;
          `E1RX_SUB_ALAW: d.data = milliwatt(1'b0, q.mw_phase);
          `E1RX_SUB_MULAW: d.data = milliwatt(1'b1, q.mw_phase);
          default: d.data = rx_byte_i;
        endcase
      end
      if (q.pay_en && q.pay_cfg[`E1RX_BIT_SNAP] && mf_sync_i)
        sig_base = q.snap[rx_ts_i];
      else
        sig_base = q.sig_mem[rx_ts_i];
      d.sigout = sig_base;
      if (q.pay_en && sig_slot_ok({2'b00, rx_ts_i}) &&
          (q.pay_cfg[`E1RX_BIT_GSTRK] || slot_cond[`E1RX_BIT_COND_EN]))
        d.sigout = slot_cond[3:0];
    end

    d.int_n = !(q.sig_cfg[`E1RX_BIT_SIGNALING_CHANGE_IRQ_ENABLE] && (|q.flags));
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      q <= '0;
      q.pay_st <= E1RX_IDLE;
      q.sig_st <= E1RX_IDLE;
      q.int_n <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;
  assign rx_data_o = q.data;
  assign rx_data_valid_o = q.dvalid;
  assign rx_ts_o = q.ts;
  assign rx_signaling_output_o = q.sigout;
  assign int_n_o = q.int_n;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence pay_launch_s;
    wr_i && addr_i == `E1RX_PAY_CONTROL && q.pay_st == E1RX_IDLE;
  endsequence

  sequence busy_pulse_s;
    q.pay_st == E1RX_XFER ##1 q.pay_st == E1RX_IDLE;
  endsequence

  pay_busy_cycle_a: assert property (pay_launch_s |=> busy_pulse_s)
    else $error("payload busy did not pulse for one cycle");
  sig_busy_cycle_a: assert property (
    wr_i && addr_i == `E1RX_SIG_CONTROL && q.sig_st == E1RX_IDLE |=>
    q.sig_st == E1RX_XFER ##1 q.sig_st == E1RX_IDLE)
    else $error("signaling busy did not pulse for one cycle");
  pay_read_load_a: assert property (
    q.pay_st == E1RX_XFER && q.pay_ctl[7] && pay_addr_ok(q.pay_ctl[6:0]) |=>
    q.pay_dat == $past(q.pay_mem[q.pay_ctl[6:0]]))
    else $error("payload read did not load the data register");
  pay_write_store_a: assert property (
    q.pay_st == E1RX_XFER && !q.pay_ctl[7] && pay_addr_ok(q.pay_ctl[6:0]) |=>
    q.pay_mem[$past(q.pay_ctl[6:0])] == $past(q.pay_dat))
    else $error("payload write did not store the data register");
  flag_clear_a: assert property (
    wr_i && addr_i == `E1RX_SIG_FLAGS0 && wdata_i[0] && !(rx_sig_valid_i && rx_sig_ts_i == 5'h01)
    |=> !q.flags[0])
    else $error("change flag not cleared by a one");
  irq_drive_a: assert property (
    q.sig_cfg[1] && (|q.flags) |=> !int_n_o)
    else $error("interrupt not asserted with a flag set");
  irq_mask_a: assert property (!q.sig_cfg[1] |=> int_n_o)
    else $error("interrupt asserted while disabled");
  freeze_hold_a: assert property (
    q.sig_cfg[3] && !(q.sig_st == E1RX_XFER) |=> $stable(q.sig_mem))
    else $error("stored signaling changed under freeze");
  gate_pass_a: assert property (
    rx_valid_i && !q.pay_en |=> rx_data_o == $past(rx_byte_i) && rx_data_valid_o)
    else $error("payload altered while functions disabled");
  trunk_replace_a: assert property (
    rx_valid_i && q.pay_en && q.pay_cfg[2:0] == 3'h1 |=>
    rx_data_o == $past(q.pay_mem[{2'b01, rx_ts_i}]))
    else $error("trunk code not substituted");

  // Indirect signaling transfers and refused accesses
  sig_read_load_a: assert property (
    q.sig_st == E1RX_XFER && q.sig_ctl[7] && sig_slot_ok(q.sig_ctl[6:0]) |=>
    q.sig_dat == {4'h0, $past(q.sig_mem[q.sig_ctl[4:0]])})
    else $error("signaling read did not load the data register");

  sig_write_store_a: assert property (
    q.sig_st == E1RX_XFER && !q.sig_ctl[7] && sig_slot_ok(q.sig_ctl[6:0]) && !rx_sig_valid_i |=>
    q.sig_mem[$past(q.sig_ctl[4:0])] == $past(q.sig_dat[3:0]))
    else $error("signaling write did not store the data register");

  pay_bad_addr_a: assert property (
    q.pay_st == E1RX_XFER && !pay_addr_ok(q.pay_ctl[6:0]) |=>
    $stable(q.pay_mem) && $stable(q.pay_dat))
    else $error("invalid payload address touched storage");

  sig_bad_addr_a: assert property (
    q.sig_st == E1RX_XFER && !sig_slot_ok(q.sig_ctl[6:0]) |=>
    $stable(q.sig_dat))
    else $error("invalid signaling address changed the data register");

  pay_refuse_a: assert property (
    wr_i && addr_i == `E1RX_PAY_CONTROL && q.pay_st == E1RX_XFER |=>
    q.pay_ctl == $past(q.pay_ctl))
    else $error("payload control accepted while busy");

  sig_refuse_a: assert property (
    wr_i && addr_i == `E1RX_SIG_CONTROL && q.sig_st == E1RX_XFER |=>
    q.sig_ctl == $past(q.sig_ctl))
    else $error("signaling control accepted while busy");

  // Received signaling: set beats clear, slot 16 never flags
  flag_set_wins_a: assert property (
    rx_sig_valid_i && rx_sig_ts_i == 5'h01 && !q.sig_cfg[3] && !q.sig_cfg[2] &&
    rx_sig_i != q.sig_mem[1] |=> q.flags[0])
    else $error("change flag not set on a new codeword");

  slot16_quiet_a: assert property (
    rx_sig_valid_i && rx_sig_ts_i == 5'h10 && !wr_i |=>
    $stable(q.flags))
    else $error("timeslot 16 raised a change flag");

  debounce_hold_a: assert property (
    rx_sig_valid_i && q.sig_cfg[2] && rx_sig_i != q.sig_prev[rx_sig_ts_i] &&
    q.sig_st != E1RX_XFER |=> $stable(q.sig_mem))
    else $error("debounce let a single codeword through");

  direct_update_a: assert property (
    rx_sig_valid_i && !q.sig_cfg[2] && !q.sig_cfg[3] && sig_slot_ok({2'b00, rx_sig_ts_i}) |=>
    q.sig_mem[$past(rx_sig_ts_i)] == $past(rx_sig_i))
    else $error("codeword not stored with debounce off");

  // Payload path replacements
  global_cond_a: assert property (
    rx_valid_i && q.pay_en && q.pay_cfg[6] && sig_slot_ok({2'b00, rx_ts_i}) |=>
    {4'h0, rx_signaling_output_o} == ($past(q.pay_mem[{2'b10, rx_ts_i}]) & 8'h0f))
    else $error("global conditioning code not applied");

  snap_use_a: assert property (
    rx_valid_i && q.pay_en && q.pay_cfg[7] && mf_sync_i && !q.pay_cfg[6] &&
    !q.pay_mem[{2'b10, rx_ts_i}][4] |=> rx_signaling_output_o == $past(q.snap[rx_ts_i]))
    else $error("snapshot signaling not used");

  slot_slot_substitution_select_a: assert property (
    rx_valid_i && q.pay_en && q.pay_cfg[2:0] == 3'h0 && q.pay_mem[{2'b00, rx_ts_i}][7:5] == 3'h1
    |=> rx_data_o == $past(q.pay_mem[{2'b01, rx_ts_i}]))
    else $error("per-slot trunk substitution missing");

  alaw_fill_a: assert property (
    rx_valid_i && q.pay_en && q.pay_cfg[2:0] == 3'h2 |=>
    rx_data_o == milliwatt(1'b0, $past(q.mw_phase)))
    else $error("A-law pattern not substituted");

  mulaw_fill_a: assert property (
    rx_valid_i && q.pay_en && q.pay_cfg[2:0] == 3'h3 |=>
    rx_data_o == milliwatt(1'b1, $past(q.mw_phase)))
    else $error("mu-law pattern not substituted");
endmodule
`default_nettype wire

/* File: core/e1rx_pkg.sv */
// Types for the E1 receive payload and signaling controls
package e1rx_pkg;
  typedef enum logic [1:0] {
    E1RX_IDLE = 2'b01,
    E1RX_XFER = 2'b10
  } e1rx_acc_t;

  typedef struct packed {
    e1rx_acc_t pay_st;
    e1rx_acc_t sig_st;
    logic [7:0] pay_ctl;
    logic [7:0] pay_dat;
    logic [7:0] pay_cfg;
    logic pay_en;
    logic [7:0] sig_cfg;
    logic [7:0] sig_ctl;
    logic [7:0] sig_dat;
    logic [29:0] flags;
    logic [95:0][7:0] pay_mem;
    logic [31:0][3:0] sig_mem;
    logic [31:0][3:0] sig_prev;
    logic [31:0][3:0] snap;
    logic [2:0] mw_phase;
    logic [7:0] data;
    logic dvalid;
    logic [4:0] ts;
    logic [3:0] sigout;
    logic int_n;
    logic [7:0] rdata;
  } e1rx_state_t;
endpackage

/* File: core/e1rx_regs.svh */
// Register offsets, field positions and reset values for the E1 receive controls
`ifndef E1RX_REGS_SVH
`define E1RX_REGS_SVH
`define E1RX_PAY_STATUS 8'hcd
`define E1RX_PAY_CONTROL 8'hce
`define E1RX_PAY_DATA 8'hcf
`define E1RX_PAY_CONFIG 8'hd0
`define E1RX_PAY_ENABLE 8'hd1
`define E1RX_SIG_CONFIG 8'hd2
`define E1RX_SIG_STATUS 8'hd3
`define E1RX_SIG_CONTROL 8'hd4
`define E1RX_SIG_DATA 8'hd5
`define E1RX_SIG_FLAGS0 8'hd6
`define E1RX_SIG_FLAGS1 8'hd7
`define E1RX_SIG_FLAGS2 8'hd8
`define E1RX_SIG_FLAGS3 8'hd9
`define E1RX_RESET_VALUE 8'h00
`define E1RX_BIT_RWN 7
`define E1RX_BIT_SNAP 7
`define E1RX_BIT_GSTRK 6
`define E1RX_BIT_FREEZE 3
`define E1RX_BIT_DEB 2
`define E1RX_BIT_SIGNALING_CHANGE_IRQ_ENABLE 1
`define E1RX_BIT_COND_EN 4
`define E1RX_CFG_MASK 8'hc7
`define E1RX_SIGCFG_MASK 8'h0e
`define E1RX_SUB_SLOT 3'h0
`define E1RX_SUB_TRUNK 3'h1
`define E1RX_SUB_ALAW 3'h2
`define E1RX_SUB_MULAW 3'h3
`define E1RX_TS_SIGNALING 5'h10
`endif

/* File: verification/e1rx_ctl_bench.sv */
// Self-checking bench for the E1 receive payload and signaling controls
`timescale 1ns/100ps
`default_nettype none
`include "e1rx_regs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %0t got %h want %h", $time, g, e); end end
module e1_rx_payload_signaling_ctl_bench;
  import e1rx_pkg::*;
  localparam logic [7:0] pc = `E1RX_PAY_CONTROL;
  localparam logic [7:0] sc = `E1RX_SIG_CONTROL;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic rxv = 1'b0;
  logic ff = 1'b0;
  logic mfs = 1'b0;
  logic sv = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rxb = 8'h00;
  logic [4:0] rxt = 5'h00;
  logic [4:0] st = 5'h00;
  logic [3:0] sval = 4'h0;
  logic [7:0] rdata_o, dat_o, d;
  logic [6:0] a;
  logic [4:0] ts_o;
  logic [3:0] sig_o;
  logic dv_o, int_n_o;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  always #5 clk_i = ~clk_i;
  e1rx_ctl u_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_valid_i(rxv), .rx_ts_i(rxt),
    .rx_byte_i(rxb), .first_frame_i(ff), .mf_sync_i(mfs), .rx_sig_valid_i(sv),
    .rx_sig_ts_i(st), .rx_sig_i(sval), .rx_data_o(dat_o), .rx_data_valid_o(dv_o),
    .rx_ts_o(ts_o), .rx_signaling_output_o(sig_o), .int_n_o(int_n_o));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      num_errors++;
      end_sim();
    end
  end
  // One bus cycle, launched just after a rising edge
  task automatic bus(input logic w, input logic r, input logic [7:0] ad, input logic [7:0] v);
    @(posedge clk_i);
    wr_i <= w;
    rd_i <= r;
    addr_i <= ad;
    wdata_i <= v;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] v);
    bus(1'b1, 1'b0, ad, v);
    bus(1'b0, 1'b0, ad, v);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    bus(1'b0, 1'b1, ad, 8'h00);
    bus(1'b0, 1'b0, ad, 8'h00);
    #1;
    `CHK(rdata_o, e)
  endtask
  // Data register, then control, then status straight after the launch
  task automatic ind(input logic [7:0] c, input logic [7:0] cv, input logic [7:0] v);
    wr(c + 8'h01, v);
    bus(1'b1, 1'b0, c, cv);
    bus(1'b0, 1'b1, c - 8'h01, 8'h00);
    bus(1'b0, 1'b0, c - 8'h01, 8'h00);
    #1;
    `CHK(rdata_o[0], 1'b1)
    rd(c - 8'h01, 8'h00);
  endtask
  task automatic rdi(input logic [7:0] c, input logic [6:0] ad, input logic [7:0] e);
    ind(c, {1'b1, ad}, 8'h00);
    rd(c + 8'h01, e);
  endtask
  task automatic rx(input logic [4:0] s, input logic [7:0] e);
    @(posedge clk_i);
    rxv <= 1'b1;
    rxt <= s;
    rxb <= 8'($urandom());
    if (e === 8'hxx)
      e = rxb;
    @(posedge clk_i);
    rxv <= 1'b0;
    #1;
    if (e === 8'hzz)
      e = rxb;
    `CHK({dv_o, ts_o}, {1'b1, s})
  endtask
  // Payload byte with a known value; expects it or a replacement
  task automatic px(input logic [4:0] s, input logic [7:0] b, input logic [7:0] e);
    @(posedge clk_i);
    rxv <= 1'b1;
    rxt <= s;
    rxb <= b;
    @(posedge clk_i);
    rxv <= 1'b0;
    #1;
    `CHK({dv_o, ts_o, dat_o}, {1'b1, s, e})
  endtask
  task automatic sg(input logic [4:0] s, input logic [3:0] v);
    @(posedge clk_i);
    sv <= 1'b1;
    st <= s;
    sval <= v;
    @(posedge clk_i);
    sv <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic clr();
    for (int i = 0; i < 4; i++)
      wr(8'hd6 + 8'(i), 8'hff);
  endtask
  function automatic logic [31:0] flag_of(input logic [4:0] s);
    flag_of = 32'h0;
    if (s >= 5'h01 && s <= 5'h0f)
      flag_of[s - 5'h01] = 1'b1;
    else if (s >= 5'h11)
      flag_of[s - 5'h02] = 1'b1;
  endfunction
  initial
  begin
    void'($urandom(32'h6187));
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int i = 8'hcd; i <= 8'hd9; i++)
      rd(8'(i), 8'h00); // register table
    rd(8'h00, 8'h00);
    $display("reset values done");
    for (int i = 0; i < 8; i++)
    begin
      a = 7'($urandom_range(0, 95));
      a = (a == 7'h40 || a == 7'h50) ? a + 7'h01 : a;
      d = 8'($urandom());
      ind(pc, {1'b0, a}, d);
      rdi(pc, a, d);
      a = 7'($urandom_range(1, 31));
      a = (a == 7'h10) ? 7'h11 : a;
      ind(sc, {1'b0, a}, d);
      rdi(sc, a, {4'h0, d[3:0]});
    end
    ind(pc, 8'hc0, 8'h3c);
    rd(pc + 8'h01, 8'h3c);
    ind(sc, 8'h90, 8'h77);
    rd(sc + 8'h01, 8'h77);
    $display("indirect access done");
    d = 8'($urandom());
    ind(pc, 8'h27, d);
    ind(pc, 8'h07, 8'h20);
    ind(pc, 8'h08, 8'h00);
    ind(pc, 8'h09, 8'h00);
    wr(`E1RX_PAY_ENABLE, 8'h01);
    wr(`E1RX_PAY_CONFIG, 8'h01);
    px(5'h07, 8'h5a, d);
    wr(`E1RX_PAY_ENABLE, 8'h00);
    px(5'h07, 8'h5a, 8'h5a);
    wr(`E1RX_PAY_ENABLE, 8'h01);
    wr(`E1RX_PAY_CONFIG, 8'h00);
    px(5'h07, 8'h66, d);
    px(5'h08, 8'h66, 8'h66);
    wr(`E1RX_PAY_CONFIG, 8'h02);
    px(5'h03, 8'h00, 8'h34);
    wr(`E1RX_PAY_CONFIG, 8'h03);
    px(5'h1f, 8'h00, 8'h1e);
    px(5'h03, 8'h00, 8'h0b);
    $display("substitution done");
    wr(`E1RX_PAY_CONFIG, 8'h00);
    ind(pc, 8'h48, 8'h05);
    ind(pc, 8'h49, 8'h1a);
    ind(sc, 8'h08, 8'h03);
    ind(sc, 8'h09, 8'h06);
    px(5'h08, 8'h11, 8'h11);
    `CHK(sig_o, 4'h3)
    px(5'h09, 8'h11, 8'h11);
    `CHK(sig_o, 4'ha)
    wr(`E1RX_PAY_CONFIG, 8'h40);
    px(5'h08, 8'h11, 8'h11);
    `CHK(sig_o, 4'h5)
    wr(`E1RX_PAY_CONFIG, 8'h80);
    mfs <= 1'b1;
    ff <= 1'b1;
    px(5'h08, 8'h22, 8'h22);
    ff <= 1'b0;
    sg(5'h08, 4'h9);
    px(5'h08, 8'h22, 8'h22);
    `CHK(sig_o, 4'h3)
    mfs <= 1'b0;
    px(5'h08, 8'h22, 8'h22);
    `CHK(sig_o, 4'h9)
    $display("conditioning and snapshot done");
    wr(`E1RX_SIG_CONFIG, 8'h02);
    for (int i = 0; i < 32; i++)
    begin
      if (i inside {3, 9, 16, 17, 31})
      begin
        sg(5'(i), 4'h1);
        clr();
        sg(5'(i), 4'h2);
        #1;
        `CHK(int_n_o, ~|flag_of(5'(i)))
        for (int j = 0; j < 4; j++)
          rd(8'hd6 + 8'(j), 8'(flag_of(5'(i)) >> (8 * j)));
      end
    end
    wr(`E1RX_SIG_FLAGS3, 8'h00);
    rd(`E1RX_SIG_FLAGS3, 8'h20);
    wr(`E1RX_SIG_FLAGS3, 8'h20);
    rd(`E1RX_SIG_FLAGS3, 8'h00);
    `CHK(int_n_o, 1'b1)
    wr(`E1RX_SIG_CONFIG, 8'h08);
    sg(5'h03, 4'h7);
    rdi(sc, 7'h03, 8'h02);
    wr(`E1RX_SIG_CONFIG, 8'h04);
    sg(5'h03, 4'hc);
    rdi(sc, 7'h03, 8'h02);
    sg(5'h03, 4'hc);
    rdi(sc, 7'h03, 8'h0c);
    rd(`E1RX_SIG_FLAGS0, 8'h04);
    `CHK(int_n_o, 1'b1)
    $display("change flags done");
    end_sim();
  end
endmodule
`default_nettype wire
